// ### dma_arb_checker.sv
// Port assertions for the data memory arbiter top.
// Assumes it is bound to dma_arb_top and sees only its ports.
`timescale 1ns/1ps
module dma_arb_checker (
   // Clock and reset
   input wire MCLK,
   input wire RST_B,
   // Register bus
   input wire WB_CYC_I,
   input wire WB_STB_I,
   input wire WB_ACK_O,
   // Masters and memory
   input wire [15:0] CPU_EA,
   input wire CPU_DONE,
   input wire DMA_DONE,
   input wire MEM_REQ,
   input wire MEM_ACK,
   input wire [23:0] MEM_ADDR,
   input wire DMA_CH_EN,
   input wire [2:0] BUS_OWNER
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RST_B);
   a_wb_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
      else $error("register access not answered");
   a_wb_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("register ack too long");
   a_one_owner: assert property ($onehot0(BUS_OWNER))
      else $error("two bus owners");
   a_mem_owned: assert property (MEM_REQ |-> $onehot(BUS_OWNER))
      else $error("memory access without owner");
   a_req_held: assert property (MEM_REQ && !MEM_ACK |=>
      MEM_REQ && $stable(MEM_ADDR) && $stable(BUS_OWNER))
      else $error("memory access changed while waiting");
   a_cpu_done: assert property (MEM_ACK && MEM_REQ && BUS_OWNER[0] |=>
      CPU_DONE && !MEM_REQ)
      else $error("cpu completion missing");
   a_no_regrant: assert property (CPU_DONE |=> !(MEM_REQ && BUS_OWNER[0]))
      else $error("finished cpu access granted again");
   a_dma_cause: assert property ($rose(DMA_DONE) |-> $past(MEM_ACK && BUS_OWNER[1]))
      else $error("dma completion without memory ack");
   a_unpaged_addr: assert property ($rose(MEM_REQ) && BUS_OWNER[0] && !$past(CPU_EA[15])
      |-> MEM_ADDR == {8'h00, $past(CPU_EA)})
      else $error("unpaged address wrong");
   a_dma_gated: assert property ($rose(MEM_REQ) && BUS_OWNER[1] |-> DMA_CH_EN)
      else $error("disabled dma granted");
endmodule
bind dma_arb_top dma_arb_checker u_chk (.*);

// ### dma_arb_eds_addr.v
// Extended data space address former for reads and writes.
// Assumes a 16-bit effective address and page registers from the register block.
`timescale 1ns/1ps
`include "dma_arb_regs.vh"
module dma_arb_eds_addr (
   // Access
   input wire [15:0] ea,
   input wire is_write,
   // Pages
   input wire [9:0] rd_page,
   input wire [8:0] wr_page,
   // Result
   output reg [23:0] eds_addr,
   output reg paged
);
   always @* begin
      eds_addr = {8'h00, ea};
      paged = 1'b0;
      if (ea[15] && is_write) begin
         eds_addr = {wr_page[8:0], ea[14:0]}; // RULE3 RULE18
         paged = 1'b1;
      end else if (ea[15] && !rd_page[9]) begin
         eds_addr = {rd_page[8:0], ea[14:0]}; // RULE2 RULE4
         paged = 1'b1;
      end
   end
endmodule

// ### dma_arb_pick.v
// Fixed priority picker for the three data memory masters.
// Assumes request bits are held by their masters until served.
`timescale 1ns/1ps
`include "dma_arb_regs.vh"
module dma_arb_pick (
   // Requests
   input wire req_cpu,
   input wire req_dma,
   input wire req_dbg,
   // Priority control
   input wire [15:0] prio,
   // One-hot winner: bit0 cpu, bit1 dma, bit2 debugger
   output reg [2:0] win
);
   always @* begin
      win = 3'b000;
      if (prio == `DMA_PRIO_DMA_UP) begin
         if (req_dma) win = 3'b010; // RULE9 RULE11
         else if (req_cpu) win = 3'b001;
         else if (req_dbg) win = 3'b100;
      end else begin
         if (req_cpu) win = 3'b001; // RULE7 RULE8
         else if (req_dma) win = 3'b010;
         else if (req_dbg) win = 3'b100;
      end
   end
endmodule

// ### dma_arb_regs.vh
// Constants for the data memory arbiter, paging and DMA register block.
// Included by every design file of the block; definitions only.
`ifndef DMA_ARB_REGS_VH
`define DMA_ARB_REGS_VH
// Register word offsets (byte address = index * 4)
`define DMA_OFF_RDPAGE 6'h00
`define DMA_OFF_WRPAGE 6'h01
`define DMA_OFF_PRIO 6'h02
`define DMA_OFF_MODDIS 6'h03
`define DMA_OFF_PAD0 6'h04
`define DMA_OFF_CNT0 6'h08
`define DMA_OFF_END 6'h0c
// Field layout
`define DMA_RDPAGE_W 10
`define DMA_WRPAGE_W 9
`define DMA_CNT_W 14
`define DMA_MODDIS_BIT 4
`define DMA_NCHAN 4
// Priority control encodings
`define DMA_PRIO_DEFAULT 16'h0000
`define DMA_PRIO_DMA_UP 16'h0020
// Reset values
`define DMA_RST_RDPAGE 10'h001
`define DMA_RST_WRPAGE 9'h001
`define DMA_RST_PRIO 16'h0000
`define DMA_RST_PAD 16'h0000
`define DMA_RST_CNT 14'h0000
`define DMA_RST_MODDIS 1'b0
`endif

// ### dma_arb_top.v
// Data memory arbiter with extended data space paging and DMA channel registers.
// Assumes a classic Wishbone master, synchronous master requests, one memory port.
// Behaviour
// RULE1: Provide 10-bit read page and 9-bit write page registers.
// RULE2: Read with page bit 9 zero and EA bit 15 forms page:EA[14:0].
// RULE3: Write with EA bit 15 set forms write page:EA[14:0].
// RULE4: Upper half of base space is the paged window for linear moves.
// RULE5: Arbitrate every data memory access among CPU, DMA and debugger.
// RULE6: Grant only the top requester; others wait until it completes.
// RULE7: Default order is CPU M0, DMA M3, debugger M4.
// RULE8: Slots M1 and M2 are unused in the default order.
// RULE9: 0x0000 default; 0x0020 puts DMA over CPU, debugger last.
// RULE10: Software writes only the two defined priority encodings.
// RULE11: Raised and lowered masters keep their relative order.
// RULE12: DMA has four independent channels with their own registers.
// RULE13: DMA accesses reach all memory through the arbiter and may stall.
// RULE14: Each channel has a 16-bit peripheral address register, reset zero.
// RULE15: Each channel has a 14-bit count, upper bits read zero.
// RULE16: Software avoids channel register writes while the channel runs.
// RULE17: Module-disable bit 4 disables all channels; other bits read zero.
// RULE18: Paged addresses span a 24-bit byte space.
// RULE19: EA bit 15 clear uses the base address unpaged.
// RULE20: A waiting master keeps its request and is served later.
`timescale 1ns/1ps
`include "dma_arb_regs.vh"
module dma_arb_top (
   // Clock and reset
   input wire MCLK,
   input wire RST_B,
   // Wishbone slave
   input wire WB_CYC_I,
   input wire WB_STB_I,
   input wire WB_WE_I,
   input wire [7:0] WB_ADR_I,
   input wire [3:0] WB_SEL_I,
   input wire [31:0] WB_DAT_I,
   output reg [31:0] WB_DAT_O,
   output reg WB_ACK_O,
   // CPU master
   input wire CPU_REQ,
   input wire CPU_WE,
   input wire [15:0] CPU_EA,
   input wire [15:0] CPU_WDATA,
   output reg CPU_DONE,
   output reg [15:0] CPU_RDATA,
   // DMA master
   input wire DMA_REQ,
   input wire DMA_WE,
   input wire [15:0] DMA_EA,
   input wire [15:0] DMA_WDATA,
   output reg DMA_DONE,
   output reg [15:0] DMA_RDATA,
   // Debugger master
   input wire DBG_REQ,
   input wire DBG_WE,
   input wire [15:0] DBG_EA,
   input wire [15:0] DBG_WDATA,
   output reg DBG_DONE,
   output reg [15:0] DBG_RDATA,
   // Data memory port
   output reg MEM_REQ,
   output reg MEM_WE,
   output reg [23:0] MEM_ADDR,
   output reg [15:0] MEM_WDATA,
   input wire MEM_ACK,
   input wire [15:0] MEM_RDATA,
   // DMA channel controls and bus owner
   output reg DMA_CH_EN,
   output reg [63:0] DMA_PAD_ALL,
   output reg [55:0] DMA_CNT_ALL,
   output reg [2:0] BUS_OWNER
);
   localparam ST_IDLE = 2'b01;
   localparam ST_BUSY = 2'b10;

   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg [9:0] rd_page_ff;
   reg [8:0] wr_page_ff;
   reg [15:0] prio_ff;
   reg moddis_ff;
   wire [63:0] pad_flat;
   wire [55:0] cnt_flat;
   reg [2:0] own_ff;
   reg [2:0] nxt_own;
   reg [31:0] rd_mux;

   wire [2:0] win;
   wire wb_req;
   wire dma_req_gated;
   reg sel_we;
   reg [15:0] sel_ea;
   reg [15:0] sel_wd;
   wire [23:0] eds_addr;

   assign wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   // Disabled channels never reach the bus
   // A finished master still requests while its done pulse stands; it must not win again
   assign dma_req_gated = DMA_REQ & ~moddis_ff & ~DMA_DONE; // RULE17 RULE13

   dma_arb_pick u_pick (
      .req_cpu(CPU_REQ & ~CPU_DONE),
      .req_dma(dma_req_gated),
      .req_dbg(DBG_REQ & ~DBG_DONE),
      .prio(prio_ff),
      .win(win)
   );

   // Address source follows the current or newly chosen owner
   always @* begin
      nxt_own = (state_ff == ST_BUSY) ? own_ff : win;
      case (nxt_own)
         3'b010: begin
            sel_we = DMA_WE;
            sel_ea = DMA_EA;
            sel_wd = DMA_WDATA;
         end
         3'b100: begin
            sel_we = DBG_WE;
            sel_ea = DBG_EA;
            sel_wd = DBG_WDATA;
         end
         default: begin
            sel_we = CPU_WE;
            sel_ea = CPU_EA;
            sel_wd = CPU_WDATA;
         end
      endcase
   end

   dma_arb_eds_addr u_addr (
      .ea(sel_ea),
      .is_write(sel_we),
      .rd_page(rd_page_ff),
      .wr_page(wr_page_ff),
      .eds_addr(eds_addr),
      .paged()
   );

   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (win != 3'b000) nxt_state = ST_BUSY; // RULE5 RULE6
         end
         ST_BUSY: begin
            if (MEM_ACK) nxt_state = ST_IDLE; // RULE20
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   // Arbitration and memory side
   always @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         state_ff <= ST_IDLE;
         own_ff <= 3'b000;
         MEM_REQ <= 1'b0;
         MEM_WE <= 1'b0;
         MEM_ADDR <= 24'h000000;
         MEM_WDATA <= 16'h0000;
         CPU_DONE <= 1'b0;
         DMA_DONE <= 1'b0;
         DBG_DONE <= 1'b0;
         CPU_RDATA <= 16'h0000;
         DMA_RDATA <= 16'h0000;
         DBG_RDATA <= 16'h0000;
         BUS_OWNER <= 3'b000;
      end else begin
         state_ff <= nxt_state;
         CPU_DONE <= 1'b0;
         DMA_DONE <= 1'b0;
         DBG_DONE <= 1'b0;
         if (state_ff == ST_IDLE && win != 3'b000) begin
            own_ff <= win; // RULE6
            BUS_OWNER <= win;
            MEM_REQ <= 1'b1;
            MEM_WE <= sel_we;
            MEM_ADDR <= eds_addr; // RULE19
            MEM_WDATA <= sel_wd;
         end else if (state_ff == ST_BUSY && MEM_ACK) begin
            MEM_REQ <= 1'b0;
            own_ff <= 3'b000;
            BUS_OWNER <= 3'b000;
            CPU_DONE <= own_ff[0];
            DMA_DONE <= own_ff[1];
            DBG_DONE <= own_ff[2];
            if (own_ff[0]) CPU_RDATA <= MEM_RDATA;
            if (own_ff[1]) DMA_RDATA <= MEM_RDATA;
            if (own_ff[2]) DBG_RDATA <= MEM_RDATA;
         end
      end
   end

   // Register read mux
   always @* begin
      rd_mux = 32'h00000000;
      case (WB_ADR_I[7:2])
         `DMA_OFF_RDPAGE: rd_mux = {22'h0, rd_page_ff};
         `DMA_OFF_WRPAGE: rd_mux = {23'h0, wr_page_ff};
         `DMA_OFF_PRIO: rd_mux = {16'h0000, prio_ff};
         `DMA_OFF_MODDIS: rd_mux = {27'h0, moddis_ff, 4'h0}; // RULE17
         default: begin
            if (WB_ADR_I[7:2] >= `DMA_OFF_PAD0 && WB_ADR_I[7:2] < `DMA_OFF_CNT0)
               rd_mux = {16'h0000, pad_flat[WB_ADR_I[3:2] * 16 +: 16]};
            else if (WB_ADR_I[7:2] >= `DMA_OFF_CNT0 && WB_ADR_I[7:2] < `DMA_OFF_END)
               rd_mux = {18'h0, cnt_flat[WB_ADR_I[3:2] * 14 +: 14]}; // RULE15
         end
      endcase
   end

   // Wishbone register writes and answer
   always @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         rd_page_ff <= `DMA_RST_RDPAGE;
         wr_page_ff <= `DMA_RST_WRPAGE;
         prio_ff <= `DMA_RST_PRIO;
         moddis_ff <= `DMA_RST_MODDIS;
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h00000000;
      end else begin
         WB_ACK_O <= wb_req;
         if (wb_req) WB_DAT_O <= rd_mux;
         if (wb_req && WB_WE_I) begin
            case (WB_ADR_I[7:2])
               `DMA_OFF_RDPAGE: begin
                  if (WB_SEL_I[0]) rd_page_ff[7:0] <= WB_DAT_I[7:0]; // RULE1
                  if (WB_SEL_I[1]) rd_page_ff[9:8] <= WB_DAT_I[9:8];
               end
               `DMA_OFF_WRPAGE: begin
                  if (WB_SEL_I[0]) wr_page_ff[7:0] <= WB_DAT_I[7:0]; // RULE1
                  if (WB_SEL_I[1]) wr_page_ff[8] <= WB_DAT_I[8];
               end
               `DMA_OFF_PRIO: begin
                  if (WB_SEL_I[0]) prio_ff[7:0] <= WB_DAT_I[7:0]; // RULE9
                  if (WB_SEL_I[1]) prio_ff[15:8] <= WB_DAT_I[15:8];
               end
               `DMA_OFF_MODDIS: begin
                  if (WB_SEL_I[0]) moddis_ff <= WB_DAT_I[`DMA_MODDIS_BIT]; // RULE17
               end
               default: begin
               end
            endcase
         end
      end
   end

   // Per-channel peripheral address and transfer count
   genvar ch;
   generate
      for (ch = 0; ch < `DMA_NCHAN; ch = ch + 1) begin : g_ch
         localparam [5:0] PAD_IDX = `DMA_OFF_PAD0 + ch;
         localparam [5:0] CNT_IDX = `DMA_OFF_CNT0 + ch;
         reg [15:0] pad_ff;
         reg [13:0] cnt_ff;
         wire hit_pad = wb_req && WB_WE_I && (WB_ADR_I[7:2] == PAD_IDX);
         wire hit_cnt = wb_req && WB_WE_I && (WB_ADR_I[7:2] == CNT_IDX);
         always @(posedge MCLK or negedge RST_B) begin
            if (!RST_B) begin
               pad_ff <= `DMA_RST_PAD;
               cnt_ff <= `DMA_RST_CNT;
            end else begin
               if (hit_pad && WB_SEL_I[0]) pad_ff[7:0] <= WB_DAT_I[7:0]; // RULE14
               if (hit_pad && WB_SEL_I[1]) pad_ff[15:8] <= WB_DAT_I[15:8];
               if (hit_cnt && WB_SEL_I[0]) cnt_ff[7:0] <= WB_DAT_I[7:0]; // RULE15
               if (hit_cnt && WB_SEL_I[1]) cnt_ff[13:8] <= WB_DAT_I[13:8];
            end
         end
         assign pad_flat[ch*16 +: 16] = pad_ff;
         assign cnt_flat[ch*14 +: 14] = cnt_ff;
      end
   endgenerate

   // Channel outputs, one driver for each whole vector
   always @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         DMA_PAD_ALL <= {4{`DMA_RST_PAD}};
         DMA_CNT_ALL <= {4{`DMA_RST_CNT}};
         DMA_CH_EN <= 1'b0;
      end else begin
         DMA_PAD_ALL <= pad_flat; // RULE12
         DMA_CNT_ALL <= cnt_flat;
         DMA_CH_EN <= ~moddis_ff; // RULE17
      end
   end
endmodule

// ### dma_mem_model.sv
// Data memory model answering the arbiter's memory port.
// Assumes the request is held until ack; latency set by the bench.
`timescale 1ns/1ps
module dma_mem_model (
   // Clock and reset
   input wire clk,
   input wire rst_b,
   // Memory port
   input wire req,
   input wire [23:0] addr,
   input wire [3:0] lat,
   output reg ack,
   output reg [15:0] rdata
);
   reg [3:0] cnt_ff;
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ack <= 1'b0;
         cnt_ff <= 4'h0;
         rdata <= 16'h0000;
      end else if (req && !ack && cnt_ff >= lat) begin
         ack <= 1'b1;
         cnt_ff <= 4'h0;
         rdata <= addr[15:0] ^ 16'h5a5a;
      end else begin
         // Data toggles outside the ack cycle so stale reads show
         ack <= 1'b0;
         cnt_ff <= (req && !ack) ? cnt_ff + 4'h1 : 4'h0;
         rdata <= ~rdata;
      end
   end
endmodule

// ### tb_dma_arb_top.sv
// Self-checking bench for the data memory arbiter top.
// Assumes dma_arb_top, the memory model and the bound checker.
`timescale 1ns/1ps
`include "dma_arb_regs.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
   $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module tb_dma_arb_top;
   reg MCLK = 0, RST_B = 0, cyc = 0, stb = 0, we = 0;
   reg [7:0] adr = 0;
   reg [31:0] dat = 0, r;
   reg [2:0] rq = 0, wq = 0;
   reg [2:0][15:0] ea = '0, wd = '0;
   reg [3:0] lat = 0;
   wire ack, mreq, mwe, mack, chen;
   wire [31:0] rdo;
   wire [2:0] done, own;
   wire [2:0][15:0] rd;
   wire [15:0] mwd, mrd;
   wire [23:0] maddr;
   wire [63:0] pads;
   wire [55:0] cnts;
   int n_fail = 0, checks = 0;
   logic [23:0] qa[$];
   logic [2:0] qo[$];
   logic [16:0] qd[$];
   dma_arb_top DUT (.MCLK(MCLK), .RST_B(RST_B), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h3), .WB_DAT_I(dat), .WB_DAT_O(rdo),
      .WB_ACK_O(ack), .CPU_REQ(rq[0]), .CPU_WE(wq[0]), .CPU_EA(ea[0]), .CPU_WDATA(wd[0]),
      .CPU_DONE(done[0]), .CPU_RDATA(rd[0]), .DMA_REQ(rq[1]), .DMA_WE(wq[1]),
      .DMA_EA(ea[1]), .DMA_WDATA(wd[1]), .DMA_DONE(done[1]), .DMA_RDATA(rd[1]),
      .DBG_REQ(rq[2]), .DBG_WE(wq[2]), .DBG_EA(ea[2]), .DBG_WDATA(wd[2]),
      .DBG_DONE(done[2]), .DBG_RDATA(rd[2]), .MEM_REQ(mreq), .MEM_WE(mwe),
      .MEM_ADDR(maddr), .MEM_WDATA(mwd), .MEM_ACK(mack), .MEM_RDATA(mrd),
      .DMA_CH_EN(chen), .DMA_PAD_ALL(pads), .DMA_CNT_ALL(cnts), .BUS_OWNER(own));
   dma_mem_model mem (.clk(MCLK), .rst_b(RST_B), .req(mreq), .addr(maddr), .lat(lat),
      .ack(mack), .rdata(mrd));
   initial forever #2 MCLK = ~MCLK;
   always @(posedge MCLK) if (mack && mreq) begin
      qa.push_back(maddr);
      qo.push_back(own);
      qd.push_back({mwe, mwd});
   end
   task wb(input w, input [5:0] i, input [15:0] d);
      int n;
      @(posedge MCLK);
      {cyc, stb, we, adr, dat} <= {2'b11, w, i, 2'b00, 16'h0, d};
      n = 0;
      do begin @(posedge MCLK); n++; end while (ack !== 1'b1 && n < 50);
      if (n == 50) n_fail++;
      r = rdo;
      {cyc, stb} <= 2'b00;
   endtask
   task rdchk(input [5:0] i, input [15:0] e);
      wb(0, i, 16'h0);
      `CHK(r, {16'h0, e})
   endtask
   // Raise the masters in m together, each drops after its completion
   task go(input [2:0] m);
      int n;
      @(posedge MCLK);
      rq <= m;
      n = 0;
      do begin @(posedge MCLK); rq <= rq & ~done; n++; end
      while ((rq & ~done) != 0 && n < 300);
      if (n == 300) n_fail++;
   endtask
   task acc(input [1:0] m, input w, input [15:0] e, input [23:0] x);
      logic [23:0] a;
      logic [16:0] d;
      ea[m] <= e;
      wq[m] <= w;
      wd[m] <= ~e;
      go(3'b001 << m);
      a = qa.pop_front();
      d = qd.pop_front();
      `CHK(a, x)
      if (w) `CHK(d, {1'b1, ~e})
      else `CHK(rd[m], x[15:0] ^ 16'h5a5a)
   endtask
   task t_regs;
      rdchk(0, `DMA_RST_RDPAGE);
      rdchk(1, `DMA_RST_WRPAGE);
      rdchk(2, 16'h0);
      wb(1, 3, 16'hffff);
      rdchk(3, 16'h0010);
      `CHK(chen, 1'b0)
      for (int c = 0; c < 4; c++) begin
         rdchk(4 + c, 16'h0);
         rdchk(8 + c, 16'h0);
         wb(1, 4 + c, 16'hf0a5 ^ c);
         wb(1, 8 + c, 16'hffff);
         rdchk(4 + c, 16'hf0a5 ^ c);
         rdchk(8 + c, 16'h3fff);
      end
      `CHK(pads, 64'hf0a6f0a7f0a4f0a5)
      `CHK(cnts, {4{14'h3fff}})
      rq <= 3'b010;
      repeat (20) @(posedge MCLK);
      `CHK(mreq, 1'b0)
      rq <= 3'b000;
      wb(1, 3, 16'h0);
      wb(1, 12, 16'hffff);
      rdchk(12, 16'h0);
      `CHK(chen, 1'b1)
      wb(1, 0, 16'hffff);
      rdchk(0, 16'h03ff);
      wb(1, 1, 16'hffff);
      rdchk(1, 16'h01ff);
      $display("test regs done");
   endtask
   task t_page;
      wb(1, 0, 16'h0005);
      wb(1, 1, 16'h0003);
      acc(0, 0, 16'h8123, {9'h005, 15'h0123});
      acc(0, 1, 16'h8123, {9'h003, 15'h0123});
      acc(1, 0, 16'h0456, 24'h000456);
      acc(2, 1, 16'hffff, {9'h003, 15'h7fff});
      wb(1, 0, 16'h0205);
      acc(0, 0, 16'h8123, 24'h008123);
      acc(2, 0, 16'h0042, 24'h000042);
      lat <= 4'h3;
      acc(1, 1, 16'h8001, {9'h003, 15'h0001});
      $display("test paging done");
   endtask
   task t_order(input [15:0] p, input [8:0] o);
      wb(1, 2, p);
      qa.delete();
      qo.delete();
      qd.delete();
      ea <= '0;
      go(3'b111);
      `CHK({qo[0], qo[1], qo[2]}, o)
      $display("test order done");
   endtask
   task test_done;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #40000;
      n_fail++;
      test_done;
   end
   initial begin
      repeat (6) @(posedge MCLK);
      RST_B <= 1'b1;
      t_regs;
      t_page;
      t_order(`DMA_PRIO_DEFAULT, 9'b001_010_100);
      t_order(`DMA_PRIO_DMA_UP, 9'b010_001_100);
      test_done;
   end
endmodule
